// ### hdl/wmac_pkg.sv
package wmac_pkg;
	localparam int CLK_PERIOD_NS    = 4;
	localparam int OSC_PERIOD_NS    = 1000;
	localparam int OSC_CYC          = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CONV_OSC_PERIODS = 17;
	localparam int CONV_CYC         = CONV_OSC_PERIODS * OSC_CYC;
	localparam int NUM_CH_DEF       = 8;

	localparam int LEN_SHORT = 8;
	localparam int LEN_LONG  = 16;
	localparam int LEN_CONV  = 12;
	localparam int LEN_WDOG0 = 17;

	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_FLAGS  = 8'h04;
	localparam logic [7:0] ADR_CHAN0  = 8'h10;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_EOC      = 4;
	localparam int ST_INT      = 5;
	localparam int ST_PFAIL    = 6;
	localparam int ST_LOCK     = 7;
	localparam int ST_INTLINE  = 8;
	localparam int FL_TAG_LSB  = 16;

	typedef enum logic [3:0] {
		MODE_WDOG  = 4'h8,
		MODE_WR1   = 4'h9,
		MODE_CONV1 = 4'ha,
		MODE_RD1   = 4'hb,
		MODE_TEST  = 4'hc,
		MODE_WRALL = 4'hd,
		MODE_AUTO  = 4'he,
		MODE_RDALL = 4'hf
	} wmac_mode_t;
	localparam wmac_mode_t RST_MODE  = MODE_WDOG;
	localparam logic       RST_PFAIL = 1'b1;

	typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_RUN = 2'b01,
		CV_DONE = 2'b11} wmac_cv_t;
	typedef enum logic [1:0] {WD_SCAN = 2'b00, WD_RESCAN = 2'b01,
		WD_ALERT = 2'b11} wmac_wd_t;
	typedef enum logic [1:0] {TX_NONE = 2'b00, TX_VEC = 2'b01,
		TX_RDALL = 2'b11} wmac_tx_t;

	typedef struct packed {
		logic       active;
		logic       frameStart;
		logic       frameEnd;
		logic       rise;
		logic       bitVal;
		logic [7:0] idx;
		logic       intLine;
	} wmac_link_t;
endpackage

// ### hdl/wmac_serial_link.sv
`timescale 1ns/100ps
module wmac_serial_link import wmac_pkg::*; (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic csPin_n,
	input  wire logic sclkPin,
	input  wire logic serialInPin,
	input  wire logic intPinIn,
	output wmac_link_t link
);
	typedef struct packed {
		logic [2:0] cs;
		logic [2:0] sclk;
		logic [1:0] sdi;
		logic [1:0] intl;
		logic [7:0] cnt;
	} wmac_lnkst_t;

	wmac_lnkst_t stReg;
	wmac_lnkst_t stNext;
	logic        rise;
	logic        frameStart;

	// Stage 0 of each pin is seen only by stage 1; all logic uses later stages.
	always_comb begin
		stNext      = stReg;
		stNext.cs   = {stReg.cs[1:0], csPin_n};
		stNext.sclk = {stReg.sclk[1:0], sclkPin};
		stNext.sdi  = {stReg.sdi[0], serialInPin};
		stNext.intl = {stReg.intl[0], intPinIn};
		frameStart  = stReg.cs[2] & ~stReg.cs[1];
		rise        = ~stReg.cs[1] & ~stReg.sclk[2] & stReg.sclk[1];
		if (frameStart) begin
			stNext.cnt = '0;
		end else if (rise && stReg.cnt != 8'hff) begin
			stNext.cnt = stReg.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stReg      <= '0;
			stReg.cs   <= 3'h7;
			stReg.intl <= 2'h3;
		end else begin
			stReg <= stNext;
		end
	end

	assign link.active     = ~stReg.cs[1];
	assign link.frameStart = frameStart;
	assign link.frameEnd   = ~stReg.cs[2] & stReg.cs[1];
	assign link.rise       = rise;
	assign link.bitVal     = stReg.sdi[1];
	assign link.idx        = stReg.cnt;
	assign link.intLine    = stReg.intl[1];

	a_count_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
		frameStart |=> stReg.cnt == 8'h00)
		else $error("bit count not restarted at select fall");
endmodule

// ### hdl/wmac_ctl.sv
`timescale 1ns/100ps
module wmac_ctl import wmac_pkg::*; #(
	parameter int NUM_CH      = NUM_CH_DEF,
	parameter int OSC_CYCLES  = OSC_CYC,
	parameter int CONV_CYCLES = CONV_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        csPin_n,
	input  wire logic        sclkPin,
	input  wire logic        serialInPin,
	output wire logic        serialOut,
	output wire logic        serialOutOe_n,
	input  wire logic        intPinIn,
	output wire logic        intOut,
	output wire logic        intOe_n,
	output wire logic        eocOut,
	output wire logic        lowBoundHit_n,
	output wire logic        highBoundHit_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output wire logic [31:0] wb_dat_o,
	output wire logic        wb_ack_o
);
	localparam int NLIM = 2 * NUM_CH;

	typedef struct packed {
		logic             ack;
		logic [31:0]      dat;
		wmac_mode_t       mode;
		logic             locked;
		logic             pfail;
		logic [3:0]       code;
		logic [15:0]      rxSh;
		logic [11:0]      cfg;
		logic [15:0][7:0] lim;
		logic [15:0][7:0] pend;
		logic [7:0][7:0]  chanVal;
		wmac_cv_t         cv;
		logic [15:0]      cvCnt;
		logic [2:0]       cvCh;
		logic [3:0]       cvInfo;
		logic [7:0]       result;
		logic [3:0]       resInfo;
		logic             resReady;
		logic [7:0]       oscCnt;
		logic             oscHalf;
		wmac_wd_t         wd;
		logic [2:0]       wdIdx;
		logic [3:0]       wdLeft;
		logic [15:0]      flags;
		logic [3:0]       tag;
		logic             intReq;
		wmac_tx_t         src;
		logic [32:0]      txVec;
		logic [7:0]       txLen;
		logic [7:0]       txPtr;
		logic             sout;
		logic             soutOe_n;
	} wmac_st_t;

	wmac_st_t   stReg;
	wmac_st_t   stNext;
	wmac_link_t lnk;
	logic       cmdDone;
	wmac_mode_t cmdMode;
	logic       wrLim;

	wmac_serial_link u_link (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.csPin_n     (csPin_n),
		.sclkPin     (sclkPin),
		.serialInPin (serialInPin),
		.intPinIn    (intPinIn),
		.link        (lnk)
	);

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	// A two-channel build ignores the two upper address bits.
	function automatic logic [3:0] limAddr(input logic [3:0] a);
		return (NUM_CH == 2) ? {2'b00, a[1:0]} : a;
	endfunction

	// Group bit 2 enables the even channel, bit 1 the odd one, and bit 0
	// joins the pair into one differential input seen on the even channel.
	function automatic logic chanOn(input logic [11:0] cfg,
		input logic [2:0] ch);
		logic [2:0] g;
		case (ch[2:1])
			2'd0: g = cfg[11:9];
			2'd1: g = cfg[8:6];
			2'd2: g = cfg[5:3];
			default: g = cfg[2:0];
		endcase
		if (g[0]) begin
			return g[2] & ~ch[0];
		end
		return ch[0] ? g[1] : g[2];
	endfunction

	function automatic logic [2:0] nextOn(input logic [11:0] cfg,
		input logic [2:0] cur);
		logic [2:0] c;
		logic       found;
		c     = cur;
		found = 1'b0;
		for (int k = 1; k <= NUM_CH; k++) begin
			if (!found && chanOn(cfg, 3'((int'(cur) + k) % NUM_CH))) begin
				c     = 3'((int'(cur) + k) % NUM_CH);
				found = 1'b1;
			end
		end
		return c;
	endfunction

	always_comb begin
		logic [15:0] newSh;
		logic [7:0]  idx;
		logic        wdTick;
		logic        hitLo;
		logic        hitHi;
		logic [3:0]  aLo;
		logic        convStart;
		logic [2:0]  convCh;
		logic [3:0]  convInfo;
		logic [3:0]  k;
		logic [7:0]  chOff;
		newSh     = {stReg.rxSh[14:0], lnk.bitVal};
		// Channel registers start at a nonzero offset, so index from it.
		chOff     = wb_adr_i - ADR_CHAN0;
		idx       = lnk.idx;
		wdTick    = 1'b0;
		hitLo     = 1'b0;
		hitHi     = 1'b0;
		aLo       = {stReg.wdIdx, 1'b0};
		convStart = 1'b0;
		convCh    = '0;
		convInfo  = '0;
		k         = '0;
		cmdDone   = 1'b0;
		cmdMode   = stReg.mode;
		wrLim     = 1'b0;
		stNext    = stReg;
		stNext.ack = 1'b0;

		// Oscillator period, halved again for the watchdog sequencer.
		if (stReg.oscCnt == 8'(OSC_CYCLES - 1)) begin
			stNext.oscCnt  = '0;
			stNext.oscHalf = ~stReg.oscHalf;
			wdTick         = stReg.oscHalf;
		end else begin
			stNext.oscCnt = stReg.oscCnt + 8'h01;
		end

		if (stReg.cv == CV_RUN) begin
			if (stReg.cvCnt == 16'(CONV_CYCLES - 1)) begin
				stNext.cv       = CV_DONE;
				stNext.result   = stReg.chanVal[stReg.cvCh];
				stNext.resInfo  = stReg.cvInfo;
				stNext.resReady = 1'b1;
			end else begin
				stNext.cvCnt = stReg.cvCnt + 16'h0001;
			end
		end

		// A readout after the alert releases the watchdog for a new scan.
		if (lnk.frameEnd) begin
			if (stReg.mode == MODE_WDOG && stReg.src == TX_VEC
				&& stReg.wd == WD_ALERT) begin
				stNext.wd     = WD_SCAN;
				stNext.flags  = '0;
				stNext.tag    = '0;
				stNext.intReq = 1'b0;
			end
			if (stReg.src == TX_VEC && stReg.resReady
				&& (stReg.mode == MODE_CONV1 || stReg.mode == MODE_AUTO)) begin
				stNext.resReady = 1'b0;
				if (stReg.mode == MODE_AUTO) begin
					convStart = 1'b1;
					convCh    = nextOn(stReg.cfg, stReg.cvCh);
					convInfo  = {1'b0, convCh};
				end
			end
			stNext.src = TX_NONE;
		end

		if (stReg.mode == MODE_WDOG && !stReg.locked && wdTick
			&& stReg.wd != WD_ALERT) begin
			stNext.wdIdx = (stReg.wdIdx == 3'(NUM_CH - 1)) ? 3'h0
				: stReg.wdIdx + 3'h1;
			if (chanOn(stReg.cfg, stReg.wdIdx)) begin
				hitLo = stReg.chanVal[stReg.wdIdx] < stReg.lim[aLo];
				hitHi = stReg.chanVal[stReg.wdIdx] > stReg.lim[aLo + 4'h1];
			end
			stNext.flags[aLo]        = stReg.flags[aLo] | hitLo;
			stNext.flags[aLo + 4'h1] = stReg.flags[aLo + 4'h1] | hitHi;
			if (stReg.wd == WD_SCAN) begin
				if (hitLo || hitHi) begin
					stNext.wd     = WD_RESCAN;
					stNext.tag    = hitLo ? aLo : aLo + 4'h1;
					stNext.wdLeft = 4'(NUM_CH - 1);
				end
			end else if (stReg.wdLeft <= 4'h1) begin
				stNext.wd     = WD_ALERT;
				stNext.intReq = 1'b1;
			end else begin
				stNext.wdLeft = stReg.wdLeft - 4'h1;
			end
		end

		if (lnk.frameStart) begin
			stNext.txPtr = '0;
			if (stReg.mode == MODE_WDOG) begin
				stNext.src   = TX_VEC;
				stNext.txVec = {stReg.tag, stReg.cfg, stReg.pfail,
					16'(stReg.flags << (16 - NLIM))};
				stNext.txLen = 8'(LEN_WDOG0 + NLIM);
			end else if (stReg.resReady && (stReg.mode == MODE_CONV1
				|| stReg.mode == MODE_AUTO)) begin
				stNext.src   = TX_VEC;
				stNext.txVec = {rev8(stReg.result), stReg.resInfo, 21'h0};
				stNext.txLen = 8'(LEN_CONV);
			end else begin
				stNext.src = TX_NONE;
			end
		end

		// Commands commit only at their last bit, so a short frame is lost.
		if (lnk.rise) begin
			stNext.rxSh = newSh;
			if (stReg.src != TX_NONE) begin
				stNext.txPtr = stReg.txPtr + 8'h01;
			end
			if (idx == 8'd3) begin
				stNext.code = newSh[3:0];
			end
			if (!stReg.locked) begin
				if (idx == 8'd3 && newSh[3:0] == MODE_TEST) begin
					stNext.locked = 1'b1;
					cmdDone       = 1'b1;
					cmdMode       = MODE_TEST;
				end else if (idx == 8'd3 && newSh[3:0] == MODE_RDALL) begin
					cmdDone      = 1'b1;
					cmdMode      = MODE_RDALL;
					stNext.src   = TX_RDALL;
					stNext.txPtr = '0;
					stNext.txLen = 8'(8 * NLIM);
				end else if (idx == 8'(LEN_SHORT - 1)
					&& stReg.code == MODE_CONV1) begin
					cmdDone   = 1'b1;
					cmdMode   = MODE_CONV1;
					convStart = 1'b1;
					convCh    = 3'(int'(newSh[2:0]) % NUM_CH);
					convInfo  = newSh[3:0];
				end else if (idx == 8'(LEN_SHORT - 1)
					&& stReg.code == MODE_RD1) begin
					cmdDone      = 1'b1;
					cmdMode      = MODE_RD1;
					stNext.src   = TX_VEC;
					stNext.txPtr = '0;
					stNext.txVec = {rev8(stReg.lim[limAddr(newSh[3:0])]), 25'h0};
					stNext.txLen = 8'(LEN_SHORT);
				end else if (idx == 8'(LEN_LONG - 1)
					&& stReg.code == MODE_WDOG) begin
					cmdDone       = 1'b1;
					cmdMode       = MODE_WDOG;
					stNext.cfg    = newSh[11:0];
					stNext.wd     = WD_SCAN;
					stNext.wdIdx  = '0;
					stNext.flags  = '0;
					stNext.tag    = '0;
					stNext.intReq = 1'b0;
				end else if (idx == 8'(LEN_LONG - 1)
					&& stReg.code == MODE_WR1) begin
					cmdDone = 1'b1;
					cmdMode = MODE_WR1;
					wrLim   = 1'b1;
					stNext.lim[limAddr(newSh[11:8])] = rev8(newSh[7:0]);
				end else if (idx == 8'(LEN_LONG - 1)
					&& stReg.code == MODE_AUTO) begin
					cmdDone    = 1'b1;
					cmdMode    = MODE_AUTO;
					stNext.cfg = newSh[11:0];
					convStart  = 1'b1;
					convCh     = nextOn(newSh[11:0], 3'(NUM_CH - 1));
					convInfo   = {1'b0, convCh};
				end else if (stReg.code == MODE_WRALL && idx >= 8'd11
					&& idx[2:0] == 3'd3) begin
					k = 4'((idx - 8'd4) >> 3);
					stNext.pend[k] = rev8(newSh[7:0]);
					if (k == 4'(NLIM - 1)) begin
						cmdDone = 1'b1;
						cmdMode = MODE_WRALL;
						wrLim   = 1'b1;
						for (int i = 0; i < NLIM; i++) begin
							stNext.lim[i] = stNext.pend[i];
						end
					end
				end
			end
		end

		if (cmdDone) begin
			stNext.mode  = cmdMode;
			stNext.pfail = 1'b0;
			if (cmdMode != MODE_CONV1 && cmdMode != MODE_AUTO) begin
				stNext.cv       = CV_IDLE;
				stNext.resReady = 1'b0;
			end
		end
		if (convStart) begin
			stNext.cv       = CV_RUN;
			stNext.cvCnt    = '0;
			stNext.cvCh     = convCh;
			stNext.cvInfo   = convInfo;
			stNext.resReady = 1'b0;
		end

		if (wb_cyc_i && wb_stb_i && !stReg.ack) begin
			stNext.ack = 1'b1;
			stNext.dat = '0;
			if (wb_adr_i == ADR_STATUS) begin
				stNext.dat[ST_MODE_LSB +: 4] = stReg.mode;
				stNext.dat[ST_EOC]           = stReg.cv != CV_RUN;
				stNext.dat[ST_INT]           = stReg.intReq;
				stNext.dat[ST_PFAIL]         = stReg.pfail;
				stNext.dat[ST_LOCK]          = stReg.locked;
				stNext.dat[ST_INTLINE]       = lnk.intLine;
			end else if (wb_adr_i == ADR_FLAGS) begin
				stNext.dat[15:0]             = stReg.flags;
				stNext.dat[FL_TAG_LSB +: 4] = stReg.tag;
			end else if (wb_adr_i >= ADR_CHAN0
				&& wb_adr_i < ADR_CHAN0 + 8'(4 * NUM_CH)) begin
				stNext.dat[7:0] = stReg.chanVal[chOff[4:2]];
				if (wb_we_i && wb_sel_i[0]) begin
					stNext.chanVal[chOff[4:2]] = wb_dat_i[7:0];
				end
			end
		end

		if (stNext.src == TX_RDALL) begin
			stNext.sout = stNext.lim[stNext.txPtr[6:3]][stNext.txPtr[2:0]];
		end else begin
			stNext.sout = stNext.txVec[6'd32 - stNext.txPtr[5:0]];
		end
		stNext.soutOe_n = !(stNext.src != TX_NONE
			&& stNext.txPtr < stNext.txLen);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stReg          <= '0;
			stReg.mode     <= RST_MODE;
			stReg.pfail    <= RST_PFAIL;
			stReg.intReq   <= 1'b1;
			stReg.wd       <= WD_ALERT;
			stReg.soutOe_n <= 1'b1;
		end else begin
			stReg <= stNext;
		end
	end

	assign serialOut      = stReg.sout;
	assign serialOutOe_n  = stReg.soutOe_n;
	assign intOut         = 1'b0;
	assign intOe_n        = ~stReg.intReq;
	assign eocOut         = stReg.cv != CV_RUN;
	assign lowBoundHit_n  = !(NUM_CH == 2 && stReg.intReq
		&& (stReg.flags[0] || stReg.flags[2]));
	assign highBoundHit_n = !(NUM_CH == 2 && stReg.intReq
		&& (stReg.flags[1] || stReg.flags[3]));
	assign wb_dat_o       = stReg.dat;
	assign wb_ack_o       = stReg.ack;

	a_pfail_cleared: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdDone |=> !stReg.pfail)
		else $error("power-fail bit survived a mode change");
	a_wdog_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
		lnk.rise && lnk.idx == 8'd15 && stReg.code == MODE_WDOG
		&& !stReg.locked |=> stReg.mode == MODE_WDOG && !stReg.intReq)
		else $error("watchdog command not taken");
	a_limit_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		lnk.rise && lnk.idx == 8'd15 && stReg.code == MODE_WR1 && !stReg.locked
		|=> stReg.lim[limAddr($past(stReg.rxSh[10:7]))]
			== rev8({$past(stReg.rxSh[6:0]), $past(lnk.bitVal)}))
		else $error("single limit stored wrongly");
	a_limit_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!wrLim |=> $stable(stReg.lim))
		else $error("limit memory changed without a complete command");
	a_eoc_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(stReg.cv == CV_RUN) |-> !eocOut [*8])
		else $error("end of conversion high during conversion");
	a_int_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(stReg.intReq) |-> $past(stReg.wd) == WD_RESCAN
		&& !intOe_n ##0 stReg.flags != 16'h0000)
		else $error("interrupt without a recorded crossing");
	a_out_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
		lnk.frameEnd |=> serialOutOe_n)
		else $error("serial output driven after select rose");
	a_test_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stReg.locked |=> stReg.locked && stReg.mode == MODE_TEST)
		else $error("test mode left without reset");
	a_wb_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus acknowledge held over two cycles");

	c_wdog_alert: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(stReg.intReq));
	c_conv_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(stReg.resReady) && stReg.mode == MODE_AUTO);
	c_read_all: cover property (@(posedge clk_sys) disable iff (!rst_n)
		stReg.src == TX_RDALL && stReg.txPtr == 8'(8 * NLIM - 1));
endmodule

// ### dv/wmac_host_model.sv
`timescale 1ns/100ps
module wmac_host_model (
	input  wire logic         clk_sys,
	input  wire logic         serialOut,
	input  wire logic         serialOutOe_n,
	output logic              csPin_n,
	output logic              sclkPin,
	output logic              serialInPin,
	output logic [255:0]      rxBits
);
	logic lastDo;
	logic doWire;

	// A floating data line shows the inverse of its last driven level, so a
	// stale bit can never pass for a fresh one.
	always @(posedge clk_sys) begin
		if (!serialOutOe_n)
			lastDo <= serialOut;
	end
	assign doWire = serialOutOe_n ? ~lastDo : serialOut;

	initial begin
		csPin_n = 1'b1;
		sclkPin = 1'b0;
		serialInPin = 1'b0;
		lastDo = 1'b0;
	end

	// The serial clock stands still outside frames; the mode code 1100 is
	// never placed in txBits by any caller.
	task automatic frame(input logic [255:0] txBits, input int n);
		@(posedge clk_sys);
		csPin_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			serialInPin <= txBits[n - 1 - i];
			repeat (4) @(posedge clk_sys);
			rxBits = {rxBits[254:0], doWire};
			sclkPin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			sclkPin <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		csPin_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin samplesChecked++; \
	if ((gt) !== (ex)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_top import wmac_pkg::*;;
	localparam int CONV = 20;
	logic         clk_sys;
	logic         rst_n;
	logic         wb_cyc_i;
	logic         wb_stb_i;
	logic         wb_we_i;
	logic [7:0]   wb_adr_i;
	logic [3:0]   wb_sel_i;
	logic [31:0]  wb_dat_i;
	logic [31:0]  wb_dat_o;
	logic         wb_ack_o;
	logic         csPin_n;
	logic         sclkPin;
	logic         serialInPin;
	logic         serialOut;
	logic         serialOutOe_n;
	logic         intOut;
	logic         intOe_n;
	logic         intWire;
	logic         eocOut;
	logic         lowHit_n;
	logic         highHit_n;
	logic [31:0]  rd;
	logic [255:0] tx;
	logic [255:0] rx;
	logic [255:0] rxHost;
	int           mismatches;
	int           samplesChecked;
	int           eocLow;
	int           eocLen;
	int           eocRuns;
	int           r;
	int           w;

	// The shared interrupt line has a pull-up.
	assign intWire = intOe_n ? 1'b1 : intOut;

	wmac_ctl #(.NUM_CH(8), .OSC_CYCLES(4), .CONV_CYCLES(CONV)) wmac_ctl_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .csPin_n(csPin_n),
		.sclkPin(sclkPin), .serialInPin(serialInPin),
		.serialOut(serialOut), .serialOutOe_n(serialOutOe_n),
		.intPinIn(intWire), .intOut(intOut), .intOe_n(intOe_n),
		.eocOut(eocOut), .lowBoundHit_n(lowHit_n),
		.highBoundHit_n(highHit_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	wmac_host_model wmac_host_model_i (
		.clk_sys(clk_sys), .serialOut(serialOut),
		.serialOutOe_n(serialOutOe_n), .csPin_n(csPin_n),
		.sclkPin(sclkPin), .serialInPin(serialInPin), .rxBits(rxHost));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (eocOut === 1'b0) begin
			eocLow++;
		end else if (eocLow != 0) begin
			eocLen = eocLow;
			eocRuns++;
			eocLow = 0;
		end
	end

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] o;
		for (int i = 0; i < 8; i++)
			o[i] = b[7 - i];
		return o;
	endfunction

	function automatic logic [7:0] lim(input int i);
		return i[0] ? (8'hf0 | 8'(i)) : 8'(i);
	endfunction

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_sys);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		`CHK("wb ack", 1'b1, wb_ack_o)
	endtask

	task automatic sframe(input int n);
		wmac_host_model_i.frame(tx, n);
		rx = rxHost;
	endtask

	task automatic waitConv(input int r0);
		for (w = 0; w < 500 && eocRuns == r0; w++)
			@(posedge clk_sys);
		`CHK("conv done", 1'b1, eocRuns != r0)
		`CHK("eoc low span", CONV, eocLen)
	endtask

	task automatic tReset();
		`CHK("int at reset", 1'b0, intOe_n)
		`CHK("eoc idle", 1'b1, eocOut)
		`CHK("do float", 1'b1, serialOutOe_n)
		wb(1'b0, ADR_STATUS, 32'h0);
		`CHK("mode", MODE_WDOG, rd[3:0])
		`CHK("pfail", 1'b1, rd[ST_PFAIL])
		`CHK("int wire", 1'b0, rd[ST_INTLINE])
		wb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
	endtask

	task automatic tPowerFail();
		tx = 256'h0;
		sframe(33);
		`CHK("pfail bit", 1'b1, rx[16])
		`CHK("int cleared", 1'b1, intOe_n)
		`CHK("do released", 1'b1, serialOutOe_n)
	endtask

	task automatic tLimits();
		tx = 256'hd;
		for (int i = 0; i < 16; i++)
			tx = (tx << 8) | 256'(rev8(lim(i)));
		sframe(132);
		tx = 256'hf << 128;
		sframe(132);
		for (int i = 0; i < 16; i++)
			`CHK("read all", lim(i), rev8(rx[8 * (15 - i) +: 8]))
		tx = 256'h9308;
		sframe(16);
		tx = 256'hb300;
		sframe(16);
		`CHK("read one", 8'h10, rev8(rx[7:0]))
		tx = 256'h93ff >> 1;
		sframe(15);
		tx = 256'hb300;
		sframe(16);
		`CHK("partial kept", 8'h10, rev8(rx[7:0]))
		wb(1'b0, ADR_STATUS, 32'h0);
		`CHK("mode now", 4'hb, rd[3:0])
		`CHK("pfail now", 1'b0, rd[ST_PFAIL])
	endtask

	task automatic tConv();
		wb(1'b1, ADR_CHAN0 + 8'h8, 32'h9c);
		r = eocRuns;
		tx = 256'ha2;
		sframe(8);
		waitConv(r);
		tx = 256'h0;
		sframe(12);
		`CHK("conv data", 8'h9c, rev8(rx[11:4]))
		`CHK("conv info", 4'h2, rx[3:0])
	endtask

	task automatic tAuto();
		wb(1'b1, ADR_CHAN0, 32'h33);
		r = eocRuns;
		tx = 256'he800;
		sframe(16);
		waitConv(r);
		r = eocRuns;
		tx = 256'h0;
		sframe(12);
		`CHK("auto data", 8'h33, rev8(rx[11:4]))
		`CHK("auto info", 4'h0, rx[3:0])
		waitConv(r);
	endtask

	task automatic tWatch();
		wb(1'b1, ADR_CHAN0, 32'h40);
		wb(1'b1, ADR_CHAN0 + 8'h4, 32'h20);
		tx = 256'h8c00;
		sframe(16);
		for (w = 0; w < 2000 && intOe_n !== 1'b0; w++)
			@(posedge clk_sys);
		`CHK("int raised", 1'b0, intOe_n)
		wb(1'b0, ADR_STATUS, 32'h0);
		`CHK("pending", 1'b1, rd[ST_INT])
		`CHK("low bound pin", 1'b1, lowHit_n)
		`CHK("high bound pin", 1'b1, highHit_n)
		tx = 256'h0;
		sframe(33);
		`CHK("tag", 4'h3, rx[32:29])
		`CHK("cfg echo", 12'hc00, rx[28:17])
		`CHK("pfail clear", 1'b0, rx[16])
		`CHK("crossings", 16'h0008, rx[15:0])
		`CHK("int released", 1'b1, intOe_n)
	endtask

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		printVerdict();
	end

	initial begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		tReset();
		tPowerFail();
		tLimits();
		tConv();
		tAuto();
		tWatch();
		printVerdict();
	end
endmodule
